//--- skc_consts.svh
/*
 * skc_consts.svh: named constants of the stepper keypad controller.
 * assumes: included by bare name from the package and the design module.
 */
`ifndef SKC_CONSTS_SVH
`define SKC_CONSTS_SVH

`define SKC_CLK_MHZ 100
`define SKC_PROMPT_MS 5000
`define SKC_PROMPT_CYCLES (`SKC_PROMPT_MS * 1000 * `SKC_CLK_MHZ)
`define SKC_STEP_BASE 1000
`define SKC_NUM_KEYS 16
`define SKC_STEPS_PER_REV 200
`define SKC_STEPS_PER_FILTER 9'h014
`define SKC_TILT_MAX 10'h10B
`define SKC_ACC_SAT 10'h3E7
`define SKC_ACC_SHIFT_MAX 10'h063
`define SKC_DEC_RADIX 10'h00A
`define SKC_WSPEED_MAX 4'h7
`define SKC_TSPEED_MAX 4'h3
`define SKC_KEY_MENU 4'hA
`define SKC_KEY_ENTER 4'hB
`define SKC_KEY_SPEED 4'hC
`define SKC_KEY_WAVE 4'hD
`define SKC_KEY_LOCAL 4'hE
`define SKC_KEY_ONLINE 4'hF
`define SKC_DIGIT_MAX 4'h9
`define SKC_MOT_TILT 0
`define SKC_MOT_WHEEL 1

`endif

//--- skc_pkg.sv
/*
 * skc_pkg.sv: types of the stepper keypad controller.
 * assumes: skc_consts.svh sits in the same folder.
 */
`include "skc_consts.svh"

package skc_pkg;
    // winding polarities of one two-winding motor
    typedef struct packed {
        logic wind_a;
        logic wind_b;
    } skc_drive_t;

    // top sequence, gray along the path through prompt and setup
    typedef enum logic [2:0] {
        ST_HOME_TILT  = 3'h0,
        ST_HOME_WHEEL = 3'h1,
        ST_PROMPT     = 3'h3,
        ST_SETUP      = 3'h2,
        ST_RUN        = 3'h6
    } skc_state_t;

    // keypad entry modes
    typedef enum logic [1:0] {
        KM_NORMAL = 2'h0,
        KM_WSPEED = 2'h1,
        KM_TSPEED = 2'h3,
        KM_WAVE   = 2'h2
    } skc_kmode_t;

    // what the display shows
    typedef enum logic [1:0] {
        SCR_HOMING = 2'h0,
        SCR_PROMPT = 2'h1,
        SCR_SETUP  = 2'h3,
        SCR_MAIN   = 2'h2
    } skc_screen_t;
endpackage

//--- skc_ctrl.sv
/*
 * skc_ctrl.sv: keypad command logic, homing sequence and two stepper
 * commutation sequencers (tilt and wheel) of a filter changer.
 * assumes: key lines and home sensors are asynchronous pins; remote
 * requests come from logic on clk; the analogue drive follows windings.
 */
`timescale 1ns/10ps
`include "skc_consts.svh"

module skc_ctrl #(
    parameter int PROMPT_CYCLES = `SKC_PROMPT_CYCLES,
    parameter int STEP_BASE = `SKC_STEP_BASE
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`SKC_NUM_KEYS-1:0] key_down, // one line per key, high while held
    input wire logic tilt_home, // optical zero sensor of tilt
    input wire logic wheel_home, // sensor at filter position zero
    input wire logic filters_loaded, // filter data present
    input wire logic rem_valid, // remote filter request, one cycle
    input wire logic [3:0] rem_filter,
    output skc_pkg::skc_drive_t tilt_drive,
    output skc_pkg::skc_drive_t wheel_drive,
    output logic move_busy,
    output logic online,
    output logic [2:0] wheel_speed,
    output logic [1:0] tilt_speed,
    output skc_pkg::skc_screen_t screen,
    output logic [8:0] wheel_pos,
    output logic [8:0] tilt_pos
);
    import skc_pkg::*;

    // next winding phase; phases run 00,01,11,10 so one winding flips per step
    function automatic logic [1:0] phase_next(input logic [1:0] ph, input logic fwd);
        logic [1:0] n;
        n = ph;
        if (fwd)
            n = {ph[0], ~ph[1]};
        else
            n = {~ph[0], ph[1]};
        return n;
    endfunction

    // index of the lowest held key, priority keeps the code stable
    function automatic logic [3:0] key_encode(input logic [`SKC_NUM_KEYS-1:0] k);
        logic [3:0] c;
        c = 4'h0;
        for (int i = `SKC_NUM_KEYS - 1; i >= 0; i--)
            if (k[i])
                c = 4'(i);
        return c;
    endfunction

    // synchronisers for pins
    logic [`SKC_NUM_KEYS-1:0] key_s1_r, key_s2_r;
    logic [1:0] home_s1_r, home_s2_r;
    // keypad tracking
    logic held_r; // a key is down
    logic [3:0] code_r; // code sampled while held
    logic press_mid_r; // the press came during a move
    skc_kmode_t kmode_r;
    logic [9:0] acc_r; // decimal tilt entry
    logic online_r;
    logic [2:0] wspeed_r;
    logic [1:0] tspeed_r;
    // top sequence
    skc_state_t st_r;
    logic [31:0] timer_r;
    skc_screen_t screen_r;
    // motors: index 0 tilt, 1 wheel
    logic [8:0] pos_r [2];
    logic [8:0] tgt_r [2];
    logic [1:0] ph_r [2];
    logic [31:0] div_r [2];
    logic busy_r;

    // pin capture
    always_ff @(posedge clk)
    begin
        key_s1_r <= key_down;
        key_s2_r <= key_s1_r;
        home_s1_r <= {wheel_home, tilt_home};
        home_s2_r <= home_s1_r;
    end

    wire any_down = |key_s2_r;
    wire released = held_r && !any_down;
    // only a keystroke wholly inside a move is dropped
    wire act = released && !(press_mid_r && busy_r);
    wire is_digit = code_r <= `SKC_DIGIT_MAX;
    wire run = st_r == ST_RUN;
    wire [9:0] acc_mul = 10'(acc_r * `SKC_DEC_RADIX + {6'h0, code_r});
    // a fourth digit would overflow three places, so the entry pins at the ceiling
    wire [9:0] acc_new = (acc_r > `SKC_ACC_SHIFT_MAX) ? `SKC_ACC_SAT : acc_mul;
    wire [8:0] filt_steps = 9'(code_r * `SKC_STEPS_PER_FILTER);
    wire [8:0] rem_steps = 9'(rem_filter * `SKC_STEPS_PER_FILTER);
    wire rem_take = rem_valid && online_r && run && (rem_filter <= `SKC_DIGIT_MAX);
    wire homing_tilt = st_r == ST_HOME_TILT;
    wire homing_wheel = st_r == ST_HOME_WHEEL;

    // key press tracking: sample while down, remember whether a move ran
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            held_r <= 1'b0;
            code_r <= 4'h0;
            press_mid_r <= 1'b0;
        end
        else if (any_down && !held_r)
        begin
            held_r <= 1'b1;
            code_r <= key_encode(key_s2_r);
            press_mid_r <= busy_r;
        end
        else if (released)
            held_r <= 1'b0;
    end

    // key actions and remote requests; these set the motor targets
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            kmode_r <= KM_NORMAL;
            acc_r <= 10'h000;
            online_r <= 1'b1; // powers up on-line
            wspeed_r <= 3'h0;
            tspeed_r <= 2'h0;
            tgt_r[0] <= 9'h000;
            tgt_r[1] <= 9'h000;
        end
        else if (act && run)
        begin
            case (code_r)
                `SKC_KEY_LOCAL: online_r <= 1'b0;
                `SKC_KEY_ONLINE: online_r <= 1'b1;
                `SKC_KEY_SPEED: kmode_r <= KM_WSPEED;
                `SKC_KEY_WAVE:
                begin
                    // speed then wave reaches tilt speed
                    kmode_r <= (kmode_r == KM_WSPEED) ? KM_TSPEED : KM_WAVE;
                    acc_r <= 10'h000;
                end
                `SKC_KEY_ENTER:
                begin
                    // out of range tilt entries are dropped silently
                    if (kmode_r == KM_WAVE && acc_r <= `SKC_TILT_MAX)
                        tgt_r[`SKC_MOT_TILT] <= acc_r[8:0];
                    kmode_r <= KM_NORMAL;
                end
                `SKC_KEY_MENU: kmode_r <= KM_NORMAL;
                default:
                begin
                    // digits; meaning depends on mode
                    case (kmode_r)
                        KM_WSPEED:
                        begin
                            if (code_r <= `SKC_WSPEED_MAX)
                                wspeed_r <= code_r[2:0];
                            kmode_r <= KM_NORMAL;
                        end
                        KM_TSPEED:
                        begin
                            if (code_r <= `SKC_TSPEED_MAX)
                                tspeed_r <= code_r[1:0];
                            kmode_r <= KM_NORMAL;
                        end
                        KM_WAVE: acc_r <= acc_new;
                        default:
                            if (is_digit)
                                tgt_r[`SKC_MOT_WHEEL] <= filt_steps;
                    endcase
                end
            endcase
        end
        else if (rem_take)
            tgt_r[`SKC_MOT_WHEEL] <= rem_steps;
    end

    // power-up sequence and prompt timer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= ST_HOME_TILT;
            timer_r <= 32'h0;
            screen_r <= SCR_HOMING;
        end
        else
        begin
            case (st_r)
                ST_HOME_TILT:
                    if (home_s2_r[`SKC_MOT_TILT])
                        st_r <= ST_HOME_WHEEL;
                ST_HOME_WHEEL:
                    if (home_s2_r[`SKC_MOT_WHEEL])
                    begin
                        st_r <= filters_loaded ? ST_RUN : ST_PROMPT;
                        screen_r <= filters_loaded ? SCR_MAIN : SCR_PROMPT;
                        timer_r <= 32'h0;
                    end
                ST_PROMPT:
                    if (timer_r >= 32'(PROMPT_CYCLES - 1))
                    begin
                        st_r <= ST_SETUP;
                        screen_r <= SCR_SETUP;
                    end
                    else
                        timer_r <= timer_r + 32'h1;
                ST_SETUP:
                    // enter leaves setup; filter data is handled elsewhere
                    if (released && code_r == `SKC_KEY_ENTER)
                    begin
                        st_r <= ST_RUN;
                        screen_r <= SCR_MAIN;
                    end
                ST_RUN: screen_r <= SCR_MAIN;
                default: st_r <= ST_HOME_TILT;
            endcase
        end
    end

    // step sequencers: one phase change per tick, reload by selected speed in run, by STEP_BASE alone while homing
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int m = 0; m < 2; m++)
            begin
                pos_r[m] <= 9'h000;
                ph_r[m] <= 2'h0;
                div_r[m] <= 32'h0;
            end
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                // homing walks backwards until the sensor fixes zero
                if ((m == `SKC_MOT_TILT && homing_tilt) || (m == `SKC_MOT_WHEEL && homing_wheel))
                begin
                    if (home_s2_r[m])
                    begin
                        pos_r[m] <= 9'h000;
                        div_r[m] <= 32'h0;
                    end
                    else if (div_r[m] == 32'h0)
                    begin
                        ph_r[m] <= phase_next(ph_r[m], 1'b0);
                        div_r[m] <= 32'(STEP_BASE - 1);
                    end
                    else
                        div_r[m] <= div_r[m] - 32'h1;
                end
                else if (run && pos_r[m] != tgt_r[m])
                begin
                    if (div_r[m] == 32'h0)
                    begin
                        ph_r[m] <= phase_next(ph_r[m], tgt_r[m] > pos_r[m]);
                        pos_r[m] <= (tgt_r[m] > pos_r[m]) ? pos_r[m] + 9'h1 : pos_r[m] - 9'h1;
                        // higher speed number means slower stepping
                        div_r[m] <= 32'((STEP_BASE <<
                            ((m == `SKC_MOT_WHEEL) ? wspeed_r : {1'b0, tspeed_r})) - 1);
                    end
                    else
                        div_r[m] <= div_r[m] - 32'h1;
                end
                // idle: windings held; divider still runs out so a new move
                // never steps sooner than the step period after the last one
                else if (div_r[m] != 32'h0)
                    div_r[m] <= div_r[m] - 32'h1;
            end
        end
    end

    // move flag: from the cycle after a target differs until the cycle after the final step lands
    always_ff @(posedge clk)
    begin
        if (reset)
            busy_r <= 1'b0;
        else
            busy_r <= run && ((pos_r[0] != tgt_r[0]) || (pos_r[1] != tgt_r[1]));
    end

    assign tilt_drive = '{wind_a: ph_r[0][1], wind_b: ph_r[0][0]};
    assign wheel_drive = '{wind_a: ph_r[1][1], wind_b: ph_r[1][0]};
    assign move_busy = busy_r;
    assign online = online_r;
    assign wheel_speed = wspeed_r;
    assign tilt_speed = tspeed_r;
    assign screen = screen_r;
    assign wheel_pos = pos_r[1];
    assign tilt_pos = pos_r[0];
endmodule

//--- skc_motor_model.sv
/* skc_motor_model.sv: two-winding stepper with a home sensor at step zero.
   assumes: drive comes from the controller on the shared clock. */
`timescale 1ns/10ps
module skc_motor_model #(
    parameter int START = 3
) (
    input wire logic clk,
    input skc_pkg::skc_drive_t drive,
    output logic home
);
    import skc_pkg::*;
    int pos = START; // rotor step count, starts off home
    skc_drive_t last_r = '0; // polarities seen last cycle
    // forward if the new state follows in 00,01,11,10 order
    always @(posedge clk)
    begin
        if (drive != last_r)
            pos <= pos + ((drive == {last_r.wind_b, ~last_r.wind_a}) ? 1 : -1);
        last_r <= drive;
    end
    // sensor marks one of the 50 repeats of a phase state
    assign home = (pos % 200 == 0);
endmodule

//--- skc_ctrl_properties.sv
/* skc_ctrl_properties.sv: port checker of the controller, bound below.
   assumes: STEP_BASE of at least 4, so steps lie 4 or more cycles apart. */
`timescale 1ns/10ps
module skc_ctrl_checker #(
    parameter int STEP_BASE = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] key_down,
    input wire logic tilt_home,
    input skc_pkg::skc_drive_t tilt_drive,
    input skc_pkg::skc_drive_t wheel_drive,
    input wire logic move_busy,
    input wire logic online,
    input skc_pkg::skc_screen_t screen,
    input wire logic [8:0] wheel_pos
);
    import skc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_tilt_one_wind: assert property (
        $changed(tilt_drive) |-> $countones(tilt_drive ^ $past(tilt_drive)) == 1)
        else $error("tilt step flipped both windings");
    a_wheel_home_rev: assert property (
        screen == SCR_HOMING && $changed(wheel_drive)
        |-> wheel_drive == {~$past(wheel_drive.wind_b), $past(wheel_drive.wind_a)})
        else $error("wheel homing step not in reverse order");
    a_tilt_home_rev: assert property (
        screen == SCR_HOMING && $changed(tilt_drive)
        |-> tilt_drive == {~$past(tilt_drive.wind_b), $past(tilt_drive.wind_a)})
        else $error("tilt homing step not in reverse order");
    a_tilt_first: assert property (
        screen == SCR_HOMING && $changed(wheel_drive) |-> $past(tilt_home, 2))
        else $error("wheel homed before tilt reached zero");
    a_step_gap: assert property (
        $changed(wheel_drive) |=> $stable(wheel_drive) [*3])
        else $error("wheel steps too close");
    a_busy_in_run: assert property (
        move_busy |-> screen == SCR_MAIN)
        else $error("move flag outside run");
    a_busy_quiet: assert property (
        $fell(move_busy) |-> $stable(wheel_drive) && $stable(tilt_drive))
        else $error("move flag dropped on a step");
    a_release_act: assert property (
        $fell(online) |-> $past(key_down, 2) == 16'h0000)
        else $error("off-line before key release");
    a_pos_unit: assert property (
        screen == SCR_MAIN && $changed(wheel_pos) |-> wheel_pos == $past(wheel_pos) + 9'h001
        || wheel_pos == $past(wheel_pos) - 9'h001)
        else $error("wheel position jumped");
endmodule
bind skc_ctrl skc_ctrl_checker #(.STEP_BASE(STEP_BASE)) i_skc_ctrl_checker (.clk(clk),
    .reset(reset), .key_down(key_down), .tilt_home(tilt_home), .tilt_drive(tilt_drive),
    .wheel_drive(wheel_drive), .move_busy(move_busy), .online(online), .screen(screen),
    .wheel_pos(wheel_pos));

//--- tb_skc_ctrl.sv
/* tb_skc_ctrl.sv: self-checking bench of the keypad and stepper controller.
   assumes: motor model and checker compiled before it. */
`timescale 1ns/10ps
module tb_skc_ctrl;
    import skc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] key_down = 16'h0000;
    logic filters_loaded = 1'b1;
    logic rem_valid = 1'b0;
    logic [3:0] rem_filter = 4'h0;
    logic tilt_home, wheel_home, move_busy, online;
    logic [2:0] wheel_speed;
    logic [1:0] tilt_speed;
    logic [8:0] wheel_pos, tilt_pos;
    skc_drive_t tilt_drive, wheel_drive, d0, td0; // d0, td0: phases at home
    skc_screen_t screen;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    skc_ctrl #(.PROMPT_CYCLES(50), .STEP_BASE(4)) i_skc_ctrl (.clk(clk), .reset(reset),
        .key_down(key_down), .tilt_home(tilt_home), .wheel_home(wheel_home),
        .filters_loaded(filters_loaded), .rem_valid(rem_valid), .rem_filter(rem_filter),
        .tilt_drive(tilt_drive), .wheel_drive(wheel_drive), .move_busy(move_busy),
        .online(online), .wheel_speed(wheel_speed), .tilt_speed(tilt_speed),
        .screen(screen), .wheel_pos(wheel_pos), .tilt_pos(tilt_pos));
    skc_motor_model #(.START(3)) i_tilt_motor (.clk(clk), .drive(tilt_drive), .home(tilt_home));
    skc_motor_model #(.START(5)) i_wheel_motor (.clk(clk), .drive(wheel_drive),
        .home(wheel_home));
    task automatic give_verdict();
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // phase after n forward steps
    function automatic skc_drive_t fwd(input skc_drive_t d, input int n);
        for (int i = 0; i < n; i++)
            d = {d.wind_b, ~d.wind_a};
        return d;
    endfunction
    // key held past the synchroniser, then released
    task automatic press(input int k);
        key_down[k] <= 1'b1;
        tick(4);
        key_down <= 16'h0000;
        tick(8);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 6000 && move_busy !== 1'b0; n++)
            tick(1);
        check(move_busy, 1'b0);
    endtask
    task automatic wait_screen(input skc_screen_t s);
        for (int n = 0; n < 3000 && screen !== s; n++)
            tick(1);
        check(screen, s);
    endtask
    task automatic remote(input logic [3:0] f);
        rem_valid <= 1'b1;
        rem_filter <= f;
        tick(1);
        rem_valid <= 1'b0;
        tick(8);
        wait_idle();
    endtask
    task automatic t_online();
        key_down[14] <= 1'b1;
        tick(6);
        check(online, 1'b1);
        key_down <= 16'h0000;
        tick(6);
        check(online, 1'b0);
        remote(4'h2);
        check(wheel_pos, 9'h000);
        press(15);
        check(online, 1'b1);
        remote(4'h1);
        check(wheel_pos, 9'h014);
        check(wheel_drive, d0);
    endtask
    task automatic t_speed();
        for (int k = 7; k >= 0; k--)
        begin
            press(12);
            press(k);
            check(wheel_speed, k[2:0]);
        end
        press(12);
        press(13);
        press(2);
        check(tilt_speed, 2'h2);
        press(12);
        press(10);
        press(5);
        wait_idle();
        check(wheel_pos, 9'h064);
        check(wheel_drive, d0);
        press(1);
        wait_idle();
        check(wheel_pos, 9'h014);
        check(wheel_drive, d0);
    endtask
    task automatic t_busy();
        press(3);
        press(5);
        wait_idle();
        check(wheel_pos, 9'h03C);
        press(0);
        check(move_busy, 1'b1);
        key_down[2] <= 1'b1;
        wait_idle();
        key_down <= 16'h0000;
        tick(8);
        wait_idle();
        check(wheel_pos, 9'h028);
    endtask
    task automatic t_tilt();
        press(13);
        press(2);
        press(6);
        press(8);
        press(11);
        check(tilt_pos, 9'h000);
        press(13);
        press(2);
        press(6);
        press(7);
        press(11);
        wait_idle();
        check(tilt_pos, 9'h10B);
        check(tilt_drive, fwd(td0, 267));
    endtask
    // second reset with no filter data: prompt, then setup
    task automatic t_prompt();
        int n;
        filters_loaded <= 1'b0;
        reset <= 1'b1;
        tick(5);
        reset <= 1'b0;
        wait_screen(SCR_PROMPT);
        check(tilt_pos, 9'h000);
        for (n = 0; n < 200 && screen !== SCR_SETUP; n++)
            tick(1);
        check(n >= 48 && n <= 52, 1'b1);
        press(11);
        check(screen, SCR_MAIN);
    endtask
    initial
    begin
        tick(5);
        reset <= 1'b0;
        wait_screen(SCR_MAIN);
        check(wheel_home, 1'b1);
        d0 = wheel_drive;
        td0 = tilt_drive;
        t_online();
        t_speed();
        t_busy();
        t_tilt();
        t_prompt();
        give_verdict();
    end
endmodule
